/* rtl/bst_pkg.sv */
package bst_pkg;
	localparam int IR_WIDTH = 4;
	localparam int BYP_WIDTH = 1;
	localparam int ID_WIDTH = 32;
	localparam int BSC_COUNT_DEF = 8;
	// instruction codes
	localparam logic [3:0] INS_EXTEST = 4'h0;
	localparam logic [3:0] INS_BYPASS = 4'hF;
	localparam logic [3:0] INS_IDCODE = 4'h2;
	localparam logic [3:0] INS_HIGHZ = 4'h4;
	localparam logic [3:0] INS_CLAMP = 4'h3;
	localparam logic [3:0] INS_SAMPLE = 4'h1;
	// capture pattern of the instruction register in capture-ir
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// identification field layout
	localparam int ID_REV_LSB = 28;
	localparam int ID_PART_LSB = 12;
	localparam int ID_VEND_LSB = 1;
	localparam int ID_REV_W = 4;
	localparam int ID_PART_W = 16;
	localparam int ID_VEND_W = 11;
	// arbitrary neutral identity values
	localparam logic [3:0] ID_REV_DEF = 4'h5;
	localparam logic [15:0] ID_PART_DEF = 16'hA5C3;
	localparam logic [10:0] ID_VEND_DEF = 11'h2B6;
	// timing: minimum test clock period, system clock period, and minimum test clock period in system clock cycles
	localparam int TCK_MIN_NS = 100;
	localparam int CLK_NS = 50;
	localparam int TCK_MIN_CYC = (TCK_MIN_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [3:0] {
		BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SHF_DR, BST_EX1_DR,
		BST_PAU_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
		BST_SHF_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
	} bst_state_t;
endpackage : bst_pkg

/* rtl/bst_tap_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bst_tap_if;
	import bst_pkg::*;
	logic       tck_rise;
	logic       tck_fall;
	logic       tms;
	logic       trst;
	bst_state_t state;
	modport ctl (input tck_rise, input tms, input trst, output state);
	modport use_side (input tck_rise, input tck_fall, input state);
endinterface : bst_tap_if
`default_nettype wire

/* rtl/bst_tap_fsm.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm (
	input  wire logic clk,        // system clock
	input  wire logic rstn,       // async reset, active low
	bst_tap_if.ctl    tap         // strobes in, state out
);
	import bst_pkg::*;
	bst_state_t next_state;

	always_comb
	begin
		next_state = tap.state;
		case (tap.state)
			BST_RESET:  next_state = tap.tms ? BST_RESET : BST_IDLE;
			BST_IDLE:   next_state = tap.tms ? BST_SEL_DR : BST_IDLE;
			BST_SEL_DR: next_state = tap.tms ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: next_state = tap.tms ? BST_EX1_DR : BST_SHF_DR;
			BST_SHF_DR: next_state = tap.tms ? BST_EX1_DR : BST_SHF_DR;
			BST_EX1_DR: next_state = tap.tms ? BST_UPD_DR : BST_PAU_DR;
			BST_PAU_DR: next_state = tap.tms ? BST_EX2_DR : BST_PAU_DR;
			BST_EX2_DR: next_state = tap.tms ? BST_UPD_DR : BST_SHF_DR;
			BST_UPD_DR: next_state = tap.tms ? BST_SEL_DR : BST_IDLE;
			BST_SEL_IR: next_state = tap.tms ? BST_RESET : BST_CAP_IR;
			BST_CAP_IR: next_state = tap.tms ? BST_EX1_IR : BST_SHF_IR;
			BST_SHF_IR: next_state = tap.tms ? BST_EX1_IR : BST_SHF_IR;
			BST_EX1_IR: next_state = tap.tms ? BST_UPD_IR : BST_PAU_IR;
			BST_PAU_IR: next_state = tap.tms ? BST_EX2_IR : BST_PAU_IR;
			BST_EX2_IR: next_state = tap.tms ? BST_UPD_IR : BST_SHF_IR;
			BST_UPD_IR: next_state = tap.tms ? BST_SEL_DR : BST_IDLE;
			default:    next_state = BST_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tap.state <= BST_RESET;
		else if (tap.trst)
			tap.state <= BST_RESET;
		else if (tap.tck_rise)
			tap.state <= next_state;
	end
endmodule : bst_tap_fsm
`default_nettype wire

/* rtl/bst_cell_chain.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_cell_chain #(
	parameter int N = bst_pkg::BSC_COUNT_DEF
) (
	input  wire logic         clk,        // system clock
	input  wire logic         rstn,       // async reset, active low
	bst_tap_if.use_side       tap,        // strobes and state
	input  wire logic         sel,        // chain is on the serial path
	input  wire logic [N-1:0] pin_value,  // live pin values to capture
	input  wire logic         ser_in,     // serial data in
	output logic              ser_out,    // serial data out (lsb)
	output logic [N-1:0]      upd         // update latches
);
	import bst_pkg::*;
	logic [N-1:0] shf;
	wire cap_en = sel && tap.tck_rise && tap.state == BST_CAP_DR;
	wire shf_en = sel && tap.tck_rise && tap.state == BST_SHF_DR;
	wire upd_en = sel && tap.tck_fall && tap.state == BST_UPD_DR;

	assign ser_out = shf[0];

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_cell
			logic sin;
			if (i == N - 1)
				assign sin = ser_in;
			else
				assign sin = shf[i+1];
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					shf[i] <= 1'b0;
				else if (cap_en)
					shf[i] <= pin_value[i];
				else if (shf_en)
					shf[i] <= sin;
			end
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					upd[i] <= 1'b0;
				else if (upd_en)
					upd[i] <= shf[i];
			end
		end
	endgenerate
endmodule : bst_cell_chain
`default_nettype wire

/* rtl/bst_tap_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_top #(
	parameter int         NIN  = 4,
	parameter int         NOUT = 4,
	parameter logic [3:0] ID_REV  = bst_pkg::ID_REV_DEF,
	parameter logic [15:0] ID_PART = bst_pkg::ID_PART_DEF,
	parameter logic [10:0] ID_VEND = bst_pkg::ID_VEND_DEF
) (
	input  wire logic            clk,       // 20 MHz system clock
	input  wire logic            rstn,      // async reset, active low
	input  wire logic            tck,       // test clock pin
	input  wire logic            tms,       // test mode select pin
	input  wire logic            tdi,       // test data in pin
	input  wire logic            trst_n,    // test reset pin, active low
	output logic                 tdo,       // test data out
	output logic                 tdo_oe,    // tdo drive enable
	input  wire logic [NIN-1:0]  core_in,   // functional input pins
	input  wire logic [NOUT-1:0] core_out,  // core drive for outputs
	input  wire logic [NOUT-1:0] core_oe,   // core enables for outputs
	output logic [NOUT-1:0]      pin_out,   // value to output pins
	output logic [NOUT-1:0]      pin_oe     // enables of output pins
);
	import bst_pkg::*;
	localparam int NC = NIN + 2 * NOUT;

	// two-flop synchronisers for the test pins
	logic [3:0] sy1;
	logic [3:0] sy2;
	logic       tck_d;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sy1   <= 4'h0;
			sy2   <= 4'h0;
			tck_d <= 1'b0;
		end
		else
		begin
			sy1   <= {tck, tms, tdi, ~trst_n};
			sy2   <= sy1;
			tck_d <= sy2[3];
		end
	end
	wire tck_s  = sy2[3];
	wire tms_s  = sy2[2];
	wire tdi_s  = sy2[1];
	wire trst_s = sy2[0];

	bst_tap_if tap ();
	assign tap.tck_rise = tck_s & ~tck_d;
	assign tap.tck_fall = ~tck_s & tck_d;
	assign tap.tms      = tms_s;
	assign tap.trst     = trst_s;

	bst_tap_fsm u_fsm (
		.clk  (clk),
		.rstn (rstn),
		.tap  (tap.ctl)
	);

	// instruction register
	logic [IR_WIDTH-1:0] ir_shf;
	logic [IR_WIDTH-1:0] instruction_shift_reg;
	wire st_reset = tap.state == BST_RESET;
	wire ir_cap   = tap.tck_rise && tap.state == BST_CAP_IR;
	wire ir_shift = tap.tck_rise && tap.state == BST_SHF_IR;
	wire ir_upd   = tap.tck_fall && tap.state == BST_UPD_IR;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ir_shf <= IR_CAPTURE;
		else if (ir_cap)
			ir_shf <= IR_CAPTURE;
		else if (ir_shift)
			ir_shf <= {tdi_s, ir_shf[IR_WIDTH-1:1]};
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			instruction_shift_reg <= INS_IDCODE;
		else if (st_reset)
			instruction_shift_reg <= INS_IDCODE;
		else if (ir_upd)
			instruction_shift_reg <= ir_shf;
	end

	// instruction decode; reserved codes fall back to bypass
	wire is_extest = instruction_shift_reg == INS_EXTEST;
	wire is_idcode = instruction_shift_reg == INS_IDCODE;
	wire is_highz  = instruction_shift_reg == INS_HIGHZ;
	wire is_clamp  = instruction_shift_reg == INS_CLAMP;
	wire is_sample = instruction_shift_reg == INS_SAMPLE;
	wire sel_chain = is_extest | is_sample;
	wire sel_id    = is_idcode;
	wire sel_byp   = ~sel_chain & ~sel_id;

	// identity value
	wire [ID_WIDTH-1:0] id_value;
	assign id_value[ID_REV_LSB +: ID_REV_W]   = ID_REV;
	assign id_value[ID_PART_LSB +: ID_PART_W] = ID_PART;
	assign id_value[ID_VEND_LSB +: ID_VEND_W] = ID_VEND;
	assign id_value[0]                        = 1'b1;

	wire dr_cap   = tap.tck_rise && tap.state == BST_CAP_DR;
	wire dr_shift = tap.tck_rise && tap.state == BST_SHF_DR;
	logic [ID_WIDTH-1:0]  part_identity_reg;
	logic [BYP_WIDTH-1:0] single_bit_pass_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			part_identity_reg <= '0;
		else if (sel_id && dr_cap)
			part_identity_reg <= id_value;
		else if (sel_id && dr_shift)
			part_identity_reg <= {tdi_s, part_identity_reg[ID_WIDTH-1:1]};
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			single_bit_pass_reg <= 1'b0;
		else if (sel_byp && dr_cap)
			single_bit_pass_reg <= 1'b0;
		else if (sel_byp && dr_shift)
			single_bit_pass_reg <= tdi_s;
	end

	// cell order: inputs, output values, output enables (test pins excluded)
	// capture path sees the functional pins through two flops
	logic [NC-1:0] cap_s1;
	logic [NC-1:0] cap_s2;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cap_s1 <= '0;
			cap_s2 <= '0;
		end
		else
		begin
			cap_s1 <= {core_oe, core_out, core_in};
			cap_s2 <= cap_s1;
		end
	end
	wire [NC-1:0] pin_value = cap_s2;
	logic         chain_so;
	logic [NC-1:0] cell_upd;
	bst_cell_chain #(.N(NC)) u_chain (
		.clk       (clk),
		.rstn      (rstn),
		.tap       (tap.use_side),
		.sel       (sel_chain),
		.pin_value (pin_value),
		.ser_in    (tdi_s),
		.ser_out   (chain_so),
		.upd       (cell_upd)
	);

	// output pin muxing; sample/preload never reaches the pins
	wire            drive_cells = is_extest | is_clamp;
	wire [NOUT-1:0] cell_out    = cell_upd[NIN +: NOUT];
	wire [NOUT-1:0] cell_oe     = cell_upd[NIN+NOUT +: NOUT];
	assign pin_out = drive_cells ? cell_out : core_out;
	assign pin_oe  = is_highz ? '0 : (drive_cells ? cell_oe : core_oe);

	// serial output changes on the falling test clock edge
	wire ir_path  = tap.state == BST_SHF_IR;
	wire dr_path  = tap.state == BST_SHF_DR;
	wire next_tdo = ir_path ? ir_shf[0] :
		sel_chain ? chain_so :
		sel_id ? part_identity_reg[0] : single_bit_pass_reg[0];
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (tap.tck_fall)
		begin
			tdo    <= next_tdo;
			tdo_oe <= ir_path | dr_path;
		end
		else if (st_reset)
			tdo_oe <= 1'b0;
	end
endmodule : bst_tap_top
`default_nettype wire

/* sim/bst_tap_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_top_sva #(
	parameter int NIN  = 4,
	parameter int NOUT = 4
) (
	input wire logic            clk,      // system clock
	input wire logic            rstn,     // async reset, active low
	input wire logic            tck,      // test clock
	input wire logic            tms,      // mode select
	input wire logic            tdi,      // serial in
	input wire logic            trst_n,   // test reset, active low
	input wire logic            tdo,      // serial out
	input wire logic            tdo_oe,   // serial out enable
	input wire logic [NIN-1:0]  core_in,  // functional inputs
	input wire logic [NOUT-1:0] core_out, // core drive
	input wire logic [NOUT-1:0] core_oe,  // core enables
	input wire logic [NOUT-1:0] pin_out,  // pin values
	input wire logic [NOUT-1:0] pin_oe    // pin enables
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_reset_out_idle: assert property ($rose(rstn) |-> !tdo && !tdo_oe)
		else $error("serial out not idle after reset");
	a_trst_no_shift: assert property ((!trst_n)[*6] |-> !tdo_oe)
		else $error("shifting during test reset");
	a_trst_core_pins: assert property ((!trst_n)[*6] |->
		pin_out == core_out && pin_oe == core_oe)
		else $error("pins not on core during test reset");
	a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck))
		else $error("serial out moved with test clock high");
	a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck))
		else $error("serial enable moved with test clock high");
	a_tdo_hold_high: assert property ($rose(tck) |=> $stable(tdo)[*2])
		else $error("serial out moved after test clock rise");
	a_oe_rise_low: assert property ($rose(tdo_oe) |-> !$past(tck, 2))
		else $error("serial enable rose without a test clock fall");
	a_pins_on_fall: assert property (($changed(pin_out) ||
		$changed(pin_oe)) && $stable(core_out) && $stable(core_oe) |->
		!$past(tck) || !trst_n)
		else $error("pins moved without cause");
endmodule : bst_tap_top_sva
bind bst_tap_top bst_tap_top_sva #(.NIN(NIN), .NOUT(NOUT)) i_bst_tap_top_sva (
	.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
	.tdo(tdo), .tdo_oe(tdo_oe), .core_in(core_in), .core_out(core_out),
	.core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* sim/bst_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
	output logic      tck,  // test clock, still between scans
	output logic      tms,  // mode select
	output logic      tdi,  // serial data to device
	input  wire logic tdo   // serial data from device
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 400 ns period; tdo taken just before the rise
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#200;
		q = tdo;
		tck = 1'b1;
		#200;
		tck = 1'b0;
	endtask : tick
	// from idle, scan n bits lsb first through dr or ir, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		#50;
		tick(1'b0, 1'b0, q);
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tdi = ~tdi;
	endtask : scan
endmodule : bst_ctl_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bst_pkg::*;
	localparam int NIN  = 4;
	localparam int NOUT = 4;
	localparam int NC   = NIN + 2 * NOUT;
	logic            clk, rstn, trst_n, tck, tms, tdi, tdo, tdo_oe;
	logic [NIN-1:0]  core_in;
	logic [NOUT-1:0] core_out, core_oe, pin_out, pin_oe;
	int              errors = 0;
	int              checked = 0;
	bst_tap_top #(.NIN(NIN), .NOUT(NOUT)) i_bst_tap_top (.clk(clk),
		.rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe), .core_in(core_in), .core_out(core_out),
		.core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
	bst_ctl_model i_bst_ctl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] exp_id();
		return {ID_REV_DEF, ID_PART_DEF, ID_VEND_DEF, 1'b1};
	endfunction : exp_id
	task automatic cmp_scan(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_scan
	task automatic cmp_pins(input logic [NOUT-1:0] eo, input logic [NOUT-1:0] ee);
		cmp_scan(32'({pin_oe, pin_out}), 32'({ee, eo}));
	endtask : cmp_pins
	task automatic ir(input logic [3:0] c);
		logic [31:0] q;
		i_bst_ctl_model.scan(1'b1, 4, 32'(c), q);
		cmp_scan(32'(q[3:0]), 32'(IR_CAPTURE));
	endtask : ir
	// serial path through the pass register: one bit late, captured zero
	task automatic byp();
		logic [31:0] d, q;
		d = $urandom;
		i_bst_ctl_model.scan(1'b0, 8, d, q);
		cmp_scan(q, 32'({d[6:0], 1'b0}));
	endtask : byp
	task automatic set_core();
		@(negedge clk);
		{core_oe, core_out, core_in} = NC'($urandom);
		@(negedge clk);
	endtask : set_core
	task automatic end_of_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		#3_000_000;
		errors++;
		end_of_test();
	end
	initial
	begin
		logic [31:0] s, p, q, cap;
		rstn = 1'b0;
		trst_n = 1'b1;
		{core_oe, core_out, core_in} = '0;
		s = $urandom(39772);
		repeat (10) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		repeat (4) @(negedge clk);
		i_bst_ctl_model.scan(1'b0, 32, $urandom, q);
		cmp_scan(q, exp_id());
		set_core();
		cap = 32'({core_oe, core_out, core_in});
		ir(INS_SAMPLE);
		p = $urandom;
		i_bst_ctl_model.scan(1'b0, NC + 4, p, q);
		cmp_scan(q, cap | ((p & 32'h0000_000F) << NC));
		cmp_pins(core_out, core_oe);
		set_core();
		ir(INS_EXTEST);
		cmp_pins(p[4+NIN+:NOUT], p[4+NIN+NOUT+:NOUT]);
		set_core();
		ir(INS_CLAMP);
		byp();
		cmp_pins(p[4+NIN+:NOUT], p[4+NIN+NOUT+:NOUT]);
		ir(INS_HIGHZ);
		byp();
		cmp_scan(32'(pin_oe), 32'h0000_0000);
		ir(INS_BYPASS);
		byp();
		// reserved code is loaded and decodes to the pass register
		ir(4'h7);
		byp();
		ir(INS_CLAMP);
		@(negedge clk) trst_n = 1'b0;
		repeat (8) @(negedge clk);
		cmp_pins(core_out, core_oe);
		trst_n = 1'b1;
		repeat (4) @(negedge clk);
		i_bst_ctl_model.scan(1'b0, 32, $urandom, q);
		cmp_scan(q, exp_id());
		end_of_test();
	end
endmodule : tb
`default_nettype wire
